// ===== rtl/swr_core.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R1] Match command selects only exactly matching device.
// [R2] Mismatched device ignores bus until reset.
// [R3] Skip command goes straight to memory functions.
// [R4] Search: send bit, complement, accept written bit.
// [R5] Search loser drops out until next reset.
// [R6] Device originates only the presence pulse.
// [R7] Master resets with at least 480 us low.
// [R8] Presence: wait 15-60 us, low 60-240 us.
// [R9] Master keeps line high 480 us after reset.
// [R10] Master reset low plus rise below 960 us.
// [R11] Falling edge starts device slot delay timer.
// [R12] Write slot sampled when delay expires.
// [R13] Master write low times and slot length.
// [R14] Read zero holds line low; one untouched.
// [R15] Read data valid 15 us after edge.
// [R16] Programming voltage copies scratchpad into memory.
// [R17] Master waits 5 us before programming pulse.
// [R18] Master waits 5 us after programming pulse.
// [R19] CRC polynomial x^8+x^5+x^4+1; ROM CRC high byte.
// [R20] Write commands: CRC over command, address, data.
// [R21] Read commands: CRC over command and address.
// [R22] Page and status data also feed CRC.
// [R23] Device never halts on CRC mismatch.
// [R24] All bytes and ROM sent LSB first.
// [R25] ROM: family byte, 48-bit serial, CRC.
// [R26] Read command transmits the 64-bit ROM.
// [R27] Low beyond 120 us treated as reset.
module swr_core #(
   // Arbitrary values; each device instance gets its own.
   parameter logic [7:0]                    FAMILY_CODE   = 8'hA5,
   parameter logic [swr_pkg::SERIAL_W-1:0]  SERIAL_NUMBER = 48'h0123456789AB,
   parameter int                            PRES_WAIT_CNT = swr_pkg::PRES_WAIT_CNT,
   parameter int                            PRES_LOW_CNT  = swr_pkg::PRES_LOW_CNT,
   parameter int                            READ_HOLD_CNT = swr_pkg::READ_HOLD_CNT,
   parameter int                            SAMPLE_CNT    = swr_pkg::SAMPLE_CNT,
   parameter int                            RST_DET_CNT   = swr_pkg::RST_DET_CNT
) (
   input  wire logic               sys_clk,
   input  wire logic               rst,
   input  wire logic               dq_in,
   output var  logic               dq_out,
   output var  logic               dq_oe_n,
   input  wire logic               vpp_detect,
   input  wire logic               mem_read_mode,
   input  wire logic [7:0]         tx_byte,
   output var  logic               tx_take,
   input  wire logic               crc_load,
   input  wire logic [7:0]         crc_seed,
   output var  logic [7:0]         crc_value,
   output var  logic               mem_selected,
   output var  swr_pkg::swr_rx_t   rx_out,
   output var  swr_pkg::swr_prog_t prog_out
);

   localparam logic [swr_pkg::CNT_W-1:0] C_PRES_WAIT = swr_pkg::CNT_W'(PRES_WAIT_CNT - 1);
   localparam logic [swr_pkg::CNT_W-1:0] C_PRES_LOW  = swr_pkg::CNT_W'(PRES_LOW_CNT - 1);
   localparam logic [swr_pkg::CNT_W-1:0] C_READ_HOLD = swr_pkg::CNT_W'(READ_HOLD_CNT);
   localparam logic [swr_pkg::CNT_W-1:0] C_SAMPLE    = swr_pkg::CNT_W'(SAMPLE_CNT);
   localparam logic [swr_pkg::CNT_W-1:0] C_RST_DET   = swr_pkg::CNT_W'(RST_DET_CNT);

   localparam logic [55:0] ROM_BODY = {SERIAL_NUMBER, FAMILY_CODE};
   localparam logic [swr_pkg::ROM_BITS-1:0] ROM_CODE =
      {swr_pkg::crc_bits56(ROM_BODY), ROM_BODY}; // [R19] [R25]

   ////////////////////////////////////////////////////////////////////////////////
   // Pin conditioning.

   logic line_lvl;
   logic vpp_lvl;

   swr_sync #(.INIT(1'b1)) u_line_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pin     (dq_in),
      .level   (line_lvl)
   );

   swr_sync #(.INIT(1'b0)) u_vpp_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pin     (vpp_detect),
      .level   (vpp_lvl)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Line timing engine.

   swr_pkg::swr_line_t         line_reg;
   swr_pkg::swr_proto_t        proto_reg;
   logic [swr_pkg::CNT_W-1:0]  cnt_reg;
   logic                       line_prev_reg;
   logic                       slot_rd_reg;
   logic                       slot_bit_reg;
   logic [5:0]                 idx_reg;
   logic [1:0]                 step_reg;
   logic [2:0]                 mem_bit_reg;
   logic [7:0]                 shift_reg;
   logic [7:0]                 tx_sh_reg;
   logic [7:0]                 scratch_reg;
   logic                       vpp_prev_reg;
   logic                       rx_valid_reg;
   logic [7:0]                 rx_data_reg;
   logic                       tx_take_reg;

   logic fall;
   logic slot_is_read;
   logic cur_tx_bit;
   logic sample_ev;
   logic read_ev;
   logic bit_ev;
   logic bit_val;
   logic rst_seen;
   logic rom_bit;
   logic last_rom;
   logic [7:0] cmd_byte;

   assign fall     = line_prev_reg && !line_lvl;
   assign rom_bit  = ROM_CODE[idx_reg];
   assign last_rom = (idx_reg == 6'(swr_pkg::ROM_BITS - 1));

   // The direction of the coming slot follows the command phase.
   always_comb begin
      slot_is_read = 1'b0;
      cur_tx_bit   = 1'b1;
      case (proto_reg)
         swr_pkg::P_READROM: begin
            slot_is_read = 1'b1;
            cur_tx_bit   = rom_bit; // [R24] [R26]
         end
         swr_pkg::P_SEARCH: begin
            slot_is_read = (step_reg != 2'd2);
            cur_tx_bit   = (step_reg == 2'd0) ? rom_bit : !rom_bit; // [R4]
         end
         swr_pkg::P_MEM: begin
            slot_is_read = mem_read_mode;
            cur_tx_bit   = (mem_bit_reg == 3'd0) ? tx_byte[0] : tx_sh_reg[0];
         end
         default: begin
            slot_is_read = 1'b0;
            cur_tx_bit   = 1'b1;
         end
      endcase
   end

   assign sample_ev = (line_reg == swr_pkg::L_SLOT) && !slot_rd_reg && (cnt_reg == C_SAMPLE);
   assign read_ev   = (line_reg == swr_pkg::L_SLOT) && slot_rd_reg && (cnt_reg == C_READ_HOLD);
   assign bit_ev    = (sample_ev || read_ev) && (proto_reg != swr_pkg::P_IDLE);
   assign bit_val   = slot_rd_reg ? slot_bit_reg : line_lvl; // [R12]
   assign rst_seen  = (line_reg == swr_pkg::L_SLOT) && !line_lvl && (cnt_reg == C_RST_DET);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         line_prev_reg <= 1'b1;
      end else begin
         line_prev_reg <= line_lvl;
      end
   end

   // A slot can be cut short only after its sample point, so a slow slot never loses its bit.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         line_reg <= swr_pkg::L_IDLE;
         cnt_reg  <= '0;
      end else begin
         case (line_reg)
            swr_pkg::L_IDLE: begin
               cnt_reg <= '0;
               if (fall) begin
                  line_reg <= swr_pkg::L_SLOT; // [R11]
               end
            end
            swr_pkg::L_SLOT: begin
               cnt_reg <= cnt_reg + 1'b1;
               if (rst_seen) begin
                  line_reg <= swr_pkg::L_RST_WAIT; // [R27]
                  cnt_reg  <= '0;
               end else if (line_lvl && cnt_reg >= C_SAMPLE) begin
                  line_reg <= swr_pkg::L_IDLE;
               end
            end
            swr_pkg::L_RST_WAIT: begin
               cnt_reg <= '0;
               if (line_lvl) begin
                  line_reg <= swr_pkg::L_PRES_WAIT;
               end
            end
            swr_pkg::L_PRES_WAIT: begin
               cnt_reg <= cnt_reg + 1'b1;
               if (cnt_reg == C_PRES_WAIT) begin
                  line_reg <= swr_pkg::L_PRES_LOW; // [R8]
                  cnt_reg  <= '0;
               end
            end
            swr_pkg::L_PRES_LOW: begin
               cnt_reg <= cnt_reg + 1'b1;
               if (cnt_reg == C_PRES_LOW) begin
                  line_reg <= swr_pkg::L_IDLE; // [R8]
                  cnt_reg  <= '0;
               end
            end
            default: begin
               line_reg <= swr_pkg::L_IDLE;
               cnt_reg  <= '0;
            end
         endcase
      end
   end

   // Slot direction and outgoing bit are frozen at the falling edge.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         slot_rd_reg  <= 1'b0;
         slot_bit_reg <= 1'b1;
      end else if (line_reg == swr_pkg::L_IDLE && fall) begin
         slot_rd_reg  <= slot_is_read;
         slot_bit_reg <= cur_tx_bit;
      end
   end

   // Open drain: only the presence pulse and read-zero bits ever pull the line.
   always_comb begin
      dq_out  = 1'b0;
      dq_oe_n = 1'b1;
      if (line_reg == swr_pkg::L_PRES_LOW) begin
         dq_oe_n = 1'b0; // [R6] [R8]
      end else if (line_reg == swr_pkg::L_SLOT && slot_rd_reg && !slot_bit_reg &&
                   proto_reg != swr_pkg::P_IDLE && cnt_reg < C_READ_HOLD) begin
         dq_oe_n = 1'b0; // [R14] [R15]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Command phases.

   assign cmd_byte = {bit_val, shift_reg[7:1]};

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         proto_reg <= swr_pkg::P_IDLE;
         idx_reg   <= '0;
         step_reg  <= '0;
         shift_reg <= '0;
      end else if (line_reg == swr_pkg::L_RST_WAIT) begin
         proto_reg <= swr_pkg::P_ROMCMD;
         idx_reg   <= '0;
         step_reg  <= '0;
         shift_reg <= '0;
      end else if (bit_ev) begin
         case (proto_reg)
            swr_pkg::P_ROMCMD: begin
               shift_reg <= cmd_byte; // [R24]
               idx_reg   <= idx_reg + 1'b1;
               if (idx_reg == 6'd7) begin
                  idx_reg <= '0;
                  case (cmd_byte)
                     swr_pkg::CMD_MATCH:  proto_reg <= swr_pkg::P_MATCH; // [R1]
                     swr_pkg::CMD_SKIP:   proto_reg <= swr_pkg::P_MEM; // [R3]
                     swr_pkg::CMD_SEARCH: proto_reg <= swr_pkg::P_SEARCH; // [R4]
                     swr_pkg::CMD_READ:   proto_reg <= swr_pkg::P_READROM; // [R26]
                     default:             proto_reg <= swr_pkg::P_IDLE;
                  endcase
               end
            end
            swr_pkg::P_MATCH: begin
               idx_reg <= idx_reg + 1'b1;
               if (bit_val != rom_bit) begin
                  proto_reg <= swr_pkg::P_IDLE; // [R2]
               end else if (last_rom) begin
                  proto_reg <= swr_pkg::P_MEM; // [R1]
               end
            end
            swr_pkg::P_READROM: begin
               idx_reg <= idx_reg + 1'b1;
               if (last_rom) begin
                  proto_reg <= swr_pkg::P_MEM;
               end
            end
            swr_pkg::P_SEARCH: begin
               step_reg <= step_reg + 1'b1;
               if (step_reg == 2'd2) begin
                  step_reg <= '0;
                  idx_reg  <= idx_reg + 1'b1;
                  if (bit_val != rom_bit) begin
                     proto_reg <= swr_pkg::P_IDLE; // [R5]
                  end else if (last_rom) begin
                     proto_reg <= swr_pkg::P_MEM;
                  end
               end
            end
            default: begin
               proto_reg <= proto_reg;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Memory-function byte stream, CRC and programming.

   logic mem_bit_ev;
   logic enter_mem;
   logic crc_ld;
   logic [7:0] crc_sd;

   assign mem_bit_ev = bit_ev && (proto_reg == swr_pkg::P_MEM);
   assign enter_mem  = (proto_reg != swr_pkg::P_MEM) && (proto_reg != swr_pkg::P_IDLE) &&
                       bit_ev && ((proto_reg == swr_pkg::P_ROMCMD && idx_reg == 6'd7 &&
                       cmd_byte == swr_pkg::CMD_SKIP) || last_rom);
   // The generator restarts on entry so the command byte is its first input.
   assign crc_ld = enter_mem || crc_load;
   assign crc_sd = crc_load ? crc_seed : swr_pkg::CRC_INIT;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mem_bit_reg  <= '0;
         tx_sh_reg    <= '0;
         rx_valid_reg <= 1'b0;
         rx_data_reg  <= '0;
         scratch_reg  <= '0;
         tx_take_reg  <= 1'b0;
      end else begin
         rx_valid_reg <= 1'b0;
         tx_take_reg  <= 1'b0;
         if (proto_reg != swr_pkg::P_MEM) begin
            mem_bit_reg <= '0;
         end else begin
            if (line_reg == swr_pkg::L_IDLE && fall && mem_read_mode && mem_bit_reg == 3'd0) begin
               tx_sh_reg   <= tx_byte;
               tx_take_reg <= 1'b1;
            end
            if (mem_bit_ev) begin
               mem_bit_reg <= mem_bit_reg + 1'b1;
               if (slot_rd_reg) begin
                  tx_sh_reg <= tx_sh_reg >> 1; // [R24]
               end else begin
                  rx_data_reg <= {bit_val, rx_data_reg[7:1]}; // [R24]
                  if (mem_bit_reg == 3'd7) begin
                     rx_valid_reg <= 1'b1;
                     scratch_reg  <= {bit_val, rx_data_reg[7:1]};
                  end
               end
            end
         end
      end
   end

   // Sent and received bits alike feed the generator; a wrong CRC never stops the stream.
   swr_crc8 u_crc (
      .sys_clk (sys_clk),
      .rst     (rst),
      .load    (crc_ld),
      .seed    (crc_sd),
      .shift   (mem_bit_ev || (bit_ev && proto_reg == swr_pkg::P_ROMCMD)), // [R20] [R21] [R22] [R23]
      .din     (bit_val),
      .crc     (crc_value)
   );

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         vpp_prev_reg <= 1'b0;
      end else begin
         vpp_prev_reg <= vpp_lvl;
      end
   end

   always_comb begin
      prog_out.en     = vpp_lvl && (proto_reg == swr_pkg::P_MEM); // [R16]
      prog_out.strobe = vpp_lvl && !vpp_prev_reg && (proto_reg == swr_pkg::P_MEM); // [R16]
      prog_out.data   = scratch_reg;
   end

   assign rx_out.valid = rx_valid_reg;
   assign rx_out.data  = rx_data_reg;
   assign tx_take      = tx_take_reg;
   assign mem_selected = (proto_reg == swr_pkg::P_MEM);

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence seq_pres_start;
      line_reg == swr_pkg::L_PRES_WAIT && cnt_reg == C_PRES_WAIT;
   endsequence

   chk_pres_start: assert property (seq_pres_start |=> !dq_oe_n[*8]) // [R8]
      else $error("presence pulse did not start after wait");

   chk_pres_end: assert property (line_reg == swr_pkg::L_PRES_LOW && // [R8]
                                  cnt_reg == C_PRES_LOW |=> dq_oe_n)
      else $error("presence pulse did not end on time");

   chk_only_drive: assert property (!dq_oe_n |-> line_reg == swr_pkg::L_PRES_LOW || // [R6]
                                    (slot_rd_reg && !slot_bit_reg))
      else $error("line driven outside presence or read zero");

   chk_read_hold: assert property (line_reg == swr_pkg::L_IDLE && fall && // [R14]
                                   slot_is_read && !cur_tx_bit && proto_reg != swr_pkg::P_IDLE
                                   |=> !dq_oe_n[*8])
      else $error("read zero released early");

   chk_read_release: assert property (cnt_reg >= C_READ_HOLD && // [R15]
                                      line_reg == swr_pkg::L_SLOT |-> dq_oe_n)
      else $error("read drive held past valid time");

   chk_match_drop: assert property (proto_reg == swr_pkg::P_MATCH && bit_ev && // [R2]
                                    bit_val != rom_bit |=> proto_reg == swr_pkg::P_IDLE)
      else $error("mismatched device stayed selected");

   chk_idle_silent: assert property (proto_reg == swr_pkg::P_IDLE && // [R2]
                                     line_reg == swr_pkg::L_SLOT |-> dq_oe_n)
      else $error("deselected device drove a slot");

   chk_skip_mem: assert property (proto_reg == swr_pkg::P_ROMCMD && bit_ev && // [R3]
                                  idx_reg == 6'd7 && cmd_byte == swr_pkg::CMD_SKIP |=> mem_selected)
      else $error("skip did not open memory functions");

   chk_search_cmp: assert property (proto_reg == swr_pkg::P_SEARCH && // [R4]
                                    step_reg == 2'd1 && line_reg == swr_pkg::L_IDLE && fall
                                    |=> slot_bit_reg == !$past(rom_bit))
      else $error("search complement bit wrong");

   chk_reset_det: assert property (rst_seen |=> line_reg == swr_pkg::L_RST_WAIT ##1 // [R27]
                                   proto_reg == swr_pkg::P_ROMCMD)
      else $error("long low not taken as reset");

   chk_prog_gate: assert property (prog_out.en |-> mem_selected && vpp_lvl) // [R16]
      else $error("program enable without selection");

endmodule
`default_nettype wire

// ===== rtl/swr_crc8.sv
`timescale 1ns/1ps
`default_nettype none
module swr_crc8 (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       load,
   input  wire logic [7:0] seed,
   input  wire logic       shift,
   input  wire logic       din,
   output var  logic [7:0] crc
);

   logic [7:0] crc_reg;

   // A load wins over a shift in the same cycle.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         crc_reg <= swr_pkg::CRC_INIT;
      end else if (load) begin
         crc_reg <= seed;
      end else if (shift) begin
         crc_reg <= swr_pkg::crc_step(crc_reg, din); // [R19]
      end
   end

   assign crc = crc_reg;

endmodule
`default_nettype wire

// ===== rtl/swr_pkg.sv
package swr_pkg;

   // Clock rate of sys_clk.
   localparam int CLK_HZ = 20_000_000;
   localparam int US_DIV = 1_000_000;

   // Line timing in microseconds, each taken from inside its documented window.
   localparam int PRESENCE_WAIT_TIME_US = 30;
   localparam int PRESENCE_LOW_TIME_US  = 120;
   localparam int READ_VALID_TIME_US    = 15;
   localparam int WRITE_SAMPLE_TIME_US  = 30;
   localparam int RESET_DETECT_TIME_US  = 120;

   localparam int PRES_WAIT_CNT = PRESENCE_WAIT_TIME_US * CLK_HZ / US_DIV;
   localparam int PRES_LOW_CNT  = PRESENCE_LOW_TIME_US * CLK_HZ / US_DIV;
   localparam int READ_HOLD_CNT = READ_VALID_TIME_US * CLK_HZ / US_DIV;
   localparam int SAMPLE_CNT    = WRITE_SAMPLE_TIME_US * CLK_HZ / US_DIV;
   localparam int RST_DET_CNT   = RESET_DETECT_TIME_US * CLK_HZ / US_DIV;
   localparam int CNT_W         = 12;

   // Command bytes.
   localparam logic [7:0] CMD_MATCH  = 8'h55;
   localparam logic [7:0] CMD_SKIP   = 8'hCC;
   localparam logic [7:0] CMD_SEARCH = 8'hF0;
   localparam logic [7:0] CMD_READ   = 8'h33;

   // ROM layout and CRC.
   localparam int ROM_BITS    = 64;
   localparam int ROM_CRC_LSB = 56;
   localparam int SERIAL_W    = 48;
   localparam logic [7:0] CRC_POLY_REFL = 8'h8C;
   localparam logic [7:0] CRC_INIT      = 8'h00;

   typedef enum logic [2:0] {
      L_IDLE, L_SLOT, L_RST_WAIT, L_PRES_WAIT, L_PRES_LOW
   } swr_line_t;

   typedef enum logic [2:0] {
      P_IDLE, P_ROMCMD, P_MATCH, P_READROM, P_SEARCH, P_MEM
   } swr_proto_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } swr_rx_t;

   typedef struct packed {
      logic       en;
      logic       strobe;
      logic [7:0] data;
   } swr_prog_t;

   // One LSB-first step of the x^8+x^5+x^4+1 generator.
   function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic din);
      logic fb;
      fb = crc[0] ^ din;
      return fb ? ((crc >> 1) ^ CRC_POLY_REFL) : (crc >> 1);
   endfunction

   function automatic logic [7:0] crc_bits56(input logic [55:0] bits);
      logic [7:0] c;
      c = CRC_INIT;
      for (int i = 0; i < ROM_CRC_LSB; i++) begin
         c = crc_step(c, bits[i]);
      end
      return c;
   endfunction

endpackage

// ===== rtl/swr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module swr_sync #(
   parameter logic INIT = 1'b1
) (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic pin,
   output var  logic level
);

   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic level_reg;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s1_reg <= INIT;
         s2_reg <= INIT;
         s3_reg <= INIT;
      end else begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // A change is taken only once two settled stages agree, which rejects a single-cycle glitch.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         level_reg <= INIT;
      end else if (s2_reg == s3_reg) begin
         level_reg <= s3_reg;
      end
   end

   assign level = level_reg;

endmodule
`default_nettype wire

// ===== sim/swr_master.sv
`timescale 1ns/1ps
`default_nettype none
// Bus master model. It only ever pulls the line low; the pull-up makes high.
module swr_master (
   input  wire logic sys_clk,
   input  wire logic line,
   output var  logic m_low
);
   initial m_low = 1'b0;
   ////////////////////////////////////////////////////////////
   task automatic bus_reset(output int w, output int l);
      w = 0;
      l = 0;
      m_low = 1'b1;
      repeat (100) @(negedge sys_clk);
      m_low = 1'b0;
      repeat (240) begin
         @(negedge sys_clk);
         if (!line) l++;
         else if (l == 0) w++;
      end
   endtask
   task automatic write_bit(input logic b);
      m_low = 1'b1;
      repeat (b ? 5 : 50) @(negedge sys_clk);
      m_low = 1'b0;
      repeat (b ? 55 : 10) @(negedge sys_clk);
   endtask
   task automatic read_bit(output logic b);
      m_low = 1'b1;
      repeat (5) @(negedge sys_clk);
      m_low = 1'b0;
      repeat (4) @(negedge sys_clk);
      b = line;
      repeat (51) @(negedge sys_clk);
   endtask
   task automatic write_vec(input logic [63:0] d, input int n);
      for (int i = 0; i < n; i++) write_bit(d[i]);
   endtask
   task automatic read_vec(output logic [63:0] d, input int n);
      d = '0;
      for (int i = 0; i < n; i++) read_bit(d[i]);
   endtask
endmodule
`default_nettype wire

// ===== sim/tb_single_wire_rom_select_and_crc.sv
`timescale 1ns/1ps
`default_nettype none
module tb_single_wire_rom_select_and_crc;
   localparam logic [7:0]  FAM = 8'hA5;           // Arbitrary value.
   localparam logic [47:0] SER = 48'h0123456789AB; // Arbitrary value.
   localparam int PW = 20;
   localparam int PL = 40;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic vpp = 1'b0;
   logic rmode = 1'b0;
   logic cload = 1'b0;
   logic [7:0] txb = 8'h00;
   logic [7:0] cseed = 8'h00;
   logic [63:0] v;
   wire logic m_low, oe_n, sel, dqo, tk;
   wire logic [7:0] crc;
   swr_pkg::swr_rx_t   rx;
   swr_pkg::swr_prog_t prog;
   // Open-drain line: low if either side pulls, pull-up otherwise.
   wire logic line = ~(m_low | (~oe_n & ~dqo));
   int err_count = 0, checks = 0, rx_n = 0, pg_n = 0, tk_n = 0;
   always #25 sys_clk = ~sys_clk;
   // Short counts keep the run small; sample stays after read hold.
   swr_core #(.FAMILY_CODE(FAM), .SERIAL_NUMBER(SER), .PRES_WAIT_CNT(PW),
      .PRES_LOW_CNT(PL), .READ_HOLD_CNT(10), .SAMPLE_CNT(20), .RST_DET_CNT(60)) dut_u (
      .sys_clk(sys_clk), .rst(rst), .dq_in(line), .dq_out(dqo), .dq_oe_n(oe_n),
      .vpp_detect(vpp), .mem_read_mode(rmode), .tx_byte(txb), .tx_take(tk),
      .crc_load(cload), .crc_seed(cseed), .crc_value(crc), .mem_selected(sel),
      .rx_out(rx), .prog_out(prog));
   swr_master m_u (.sys_clk(sys_clk), .line(line), .m_low(m_low));
   // Pulses are counted away from the launching edge, so no race decides the count.
   always @(negedge sys_clk) begin
      if (rx.valid === 1'b1) rx_n++;
      if (prog.strobe === 1'b1) pg_n++;
      if (tk === 1'b1) tk_n++;
   end
   ////////////////////////////////////////////////////////////
   function automatic logic [7:0] crc_of(input logic [63:0] d, input int n);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < n; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
      return c;
   endfunction
   function automatic logic [63:0] rom_exp();
      return {crc_of({8'h00, SER, FAM}, 56), SER, FAM};
   endfunction
   task automatic check(input string nm, input logic [63:0] e, input logic [63:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   task automatic final_report();
      $display("checks %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic t_presence();
      int w, l;
      m_u.bus_reset(w, l);
      check("presence low", 64'(PL), 64'(l));
      check("presence wait", 64'h1, 64'(w >= PW && w <= PW + 6));
   endtask
   task automatic t_read_rom();
      t_presence();
      m_u.write_vec(64'h33, 8);
      m_u.read_vec(v, 64);
      check("rom code", rom_exp(), v);
   endtask
   task automatic t_skip_write();
      int r0, p0;
      t_presence();
      m_u.write_vec(64'hCC, 8);
      check("skip select", 64'h1, 64'(sel));
      r0 = rx_n;
      p0 = pg_n;
      m_u.write_vec(64'h5A, 8);
      check("rx byte", 64'h5A, 64'(rx.data));
      check("rx pulses", 64'(r0 + 1), 64'(rx_n));
      check("write crc", 64'(crc_of(64'h5A, 8)), 64'(crc));
      repeat (5) @(negedge sys_clk);
      vpp = 1'b1;
      repeat (10) @(negedge sys_clk);
      check("prog enable", 64'h1, 64'(prog.en));
      repeat (10) @(negedge sys_clk);
      vpp = 1'b0;
      repeat (5) @(negedge sys_clk);
      check("prog release", 64'h0, 64'(prog.en));
      check("prog strobe", 64'(p0 + 1), 64'(pg_n));
      check("prog byte", 64'h5A, 64'(prog.data));
      cseed = 8'h3C;
      cload = 1'b1;
      @(negedge sys_clk);
      cload = 1'b0;
      check("crc seed", 64'h3C, 64'(crc));
   endtask
   task automatic t_read_mem();
      int k0;
      t_presence();
      m_u.write_vec(64'hCC, 8);
      rmode = 1'b1;
      txb = 8'h96;
      k0 = tk_n;
      m_u.read_vec(v, 8);
      check("read byte", 64'h96, v);
      check("tx take", 64'(k0 + 1), 64'(tk_n));
      check("read crc", 64'(crc_of(64'h96, 8)), 64'(crc));
      rmode = 1'b0;
   endtask
   task automatic t_sys_reset();
      @(negedge sys_clk);
      rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      check("reset select", 64'h0, 64'(sel));
      check("reset crc", 64'h0, 64'(crc));
      check("reset drive", 64'h1, 64'(oe_n));
   endtask
   task automatic t_bad_cmd();
      t_presence();
      m_u.write_vec(64'h0F, 8);
      m_u.write_vec(64'hCC, 8);
      check("unknown command", 64'h0, 64'(sel));
   endtask
   task automatic t_match(input logic good);
      t_presence();
      m_u.write_vec(64'h55, 8);
      m_u.write_vec(good ? rom_exp() : rom_exp() ^ 64'h1 << 40, 64);
      if (!good) m_u.write_vec(64'hCC, 8);
      check("match select", 64'(good), 64'(sel));
   endtask
   task automatic t_search(input logic lose);
      logic [63:0] r;
      logic a, b;
      r = rom_exp();
      t_presence();
      m_u.write_vec(64'hF0, 8);
      for (int i = 0; i < 64; i++) begin
         m_u.read_bit(a);
         m_u.read_bit(b);
         check("search pair", (lose && i > 3) ? 64'h3 : 64'({r[i], ~r[i]}), 64'({a, b}));
         m_u.write_bit((lose && i == 3) ? ~r[i] : r[i]);
      end
      check("search select", 64'(!lose), 64'(sel));
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(negedge sys_clk);
      rst = 1'b0;
      repeat (4) @(negedge sys_clk);
      t_read_rom();
      t_skip_write();
      t_read_mem();
      t_sys_reset();
      t_match(1'b0);
      t_match(1'b1);
      t_search(1'b1);
      t_search(1'b0);
      t_bad_cmd();
      final_report();
   end
   // The full sequence needs about 43000 cycles.
   initial begin
      repeat (60000) @(posedge sys_clk);
      err_count++;
      final_report();
   end
endmodule
`default_nettype wire
